// [hdl/ist_state_timing.sv]
// How it works
// - total states sum counts times costs
// - fetch costs 2, 6, 6+2m states
// - byte access costs 2, 3 or 3+m
// - word access costs 2, 6 or 6+2m
// - internal operation always one state
// - m equals inserted external wait states
// - register ALU ops: one fetch only
// - bit test: 1 fetch, or 2+byte
// - short branches take exactly two fetches
// - bit clear memory: 2 fetch, read, write
`timescale 1ns/1ps
`default_nettype none
module ist_state_timing (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // request
  input  wire logic              reqValid,
  input  wire ist_pkg::ist_req_t req,
  output logic                   reqReady,
  // progress
  output logic                   busy,
  output ist_pkg::ist_cyc_t      cycleType,
  output logic                   dataWrite,
  output logic                   done,
  output logic [7:0]             totalStates
);
  import ist_pkg::*;

  function automatic ist_loc_t cycle_loc(ist_cyc_t c, ist_req_t r);
    ist_loc_t l;
    l = r.fetchLoc;
    if (c == CY_STACK) begin
      l = r.stackLoc;
    end else if (c == CY_BYTE || c == CY_WORD) begin
      l = r.dataLoc;
    end
    return l;
  endfunction

  function automatic logic [7:0] cycle_cost(ist_cyc_t c, ist_req_t r);
    logic [7:0] m1;
    logic [7:0] cost;
    ist_loc_t   loc;
    m1   = {4'h0, r.waitStates};
    loc  = cycle_loc(c, r);
    cost = COST_ONCHIP_MEM;
    if (c == CY_INTERNAL) begin
      cost = COST_INTERNAL;
    end else if (c == CY_BYTE) begin
      if (loc == LOC_MOD) begin
        cost = COST_BYTE_MOD;
      end else if (loc == LOC_EXT) begin
        cost = COST_BYTE_EXT + m1;
      end
    end else if (c == CY_WORD) begin
      if (loc == LOC_MOD) begin
        cost = COST_WORD_MOD;
      end else if (loc == LOC_EXT) begin
        cost = COST_WORD_EXT + (m1 << 1);
      end
    end else begin
      // fetch, branch address read and stack share one table
      if (loc == LOC_MOD) begin
        cost = COST_FETCH_MOD;
      end else if (loc == LOC_EXT) begin
        cost = COST_FETCH_EXT + (m1 << 1);
      end
    end
    return cost;
  endfunction

  function automatic ist_cnt_t op_counts(ist_req_t r);
    ist_cnt_t n;
    n = '0;
    case (r.op)
      OP_ALU_REG: begin
        n[CY_FETCH] = CNT_FETCH_REG;
      end
      OP_BIT_TEST: begin
        n[CY_FETCH] = r.memOperand ? CNT_FETCH_MEM : CNT_FETCH_REG;
        n[CY_BYTE]  = r.memOperand ? CNT_BYTE_TEST : 2'h0;
      end
      OP_BRANCH: begin
        n[CY_FETCH] = CNT_FETCH_BRANCH;
      end
      default: begin
        n[CY_FETCH] = r.memOperand ? CNT_FETCH_MEM : CNT_FETCH_REG;
        n[CY_BYTE]  = r.memOperand ? CNT_BYTE_CLEAR : 2'h0;
      end
    endcase
    return n;
  endfunction

  function automatic logic [7:0] total_of(ist_req_t r);
    ist_cnt_t   n;
    logic [7:0] sum;
    logic [7:0] c;
    n   = op_counts(r);
    sum = 8'h00;
    for (int i = 0; i < NUM_CYC; i++) begin
      c   = cycle_cost(ist_cyc_t'(3'(i)), r);
      sum = sum + (n[i][0] ? c : 8'h00) + (n[i][1] ? (c << 1) : 8'h00);
    end
    return sum;
  endfunction

  function automatic ist_cyc_t first_cyc(ist_cnt_t n);
    ist_cyc_t t;
    t = CY_INTERNAL;
    for (int i = NUM_CYC - 1; i >= 0; i--) begin
      if (n[i] != 2'h0) begin
        t = ist_cyc_t'(3'(i));
      end
    end
    return t;
  endfunction

  ist_state_t state_r;
  ist_req_t   req_r;
  ist_cnt_t   cnt_r;
  logic [7:0] stateLeft_r;
  logic       reqReady_r;
  logic       busy_r;
  ist_cyc_t   cycleType_r;
  logic       dataWrite_r;
  logic       done_r;
  logic [7:0] totalStates_r;

  logic       start;
  logic       cycEnd;
  logic       moreCyc;
  ist_req_t   srcReq;
  ist_cnt_t   srcCnt;
  ist_cnt_t   decCnt;
  ist_cyc_t   selType;
  logic [7:0] selCost;

  assign start   = reqValid && state_r == S_IDLE;
  assign cycEnd  = state_r == S_RUN && stateLeft_r == 8'h01;
  assign moreCyc = |cnt_r;
  assign srcReq  = start ? req : req_r;
  assign srcCnt  = start ? op_counts(req) : cnt_r;
  assign selType = first_cyc(srcCnt);
  assign selCost = cycle_cost(selType, srcReq);

  always_comb begin
    decCnt          = srcCnt;
    decCnt[selType] = srcCnt[selType] - 2'h1;
  end

  // sequencer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (reqValid) begin
            state_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (cycEnd && !moreCyc) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // cycle walk: one state per clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_r       <= '0;
      cnt_r       <= '0;
      stateLeft_r <= 8'h00;
      cycleType_r <= CY_FETCH;
      dataWrite_r <= 1'b0;
    end else if (start || (cycEnd && moreCyc)) begin
      req_r       <= srcReq;
      cnt_r       <= decCnt;
      stateLeft_r <= selCost;
      cycleType_r <= selType;
      // second byte access of a memory bit clear writes back
      dataWrite_r <= selType == CY_BYTE && srcReq.op == OP_BIT_CLEAR
                     && srcCnt[CY_BYTE] == 2'h1;
    end else if (state_r == S_RUN && stateLeft_r != 8'h00) begin
      stateLeft_r <= stateLeft_r - 8'h01;
      if (cycEnd) begin
        dataWrite_r <= 1'b0;
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reqReady_r    <= 1'b1;
      busy_r        <= 1'b0;
      done_r        <= 1'b0;
      totalStates_r <= 8'h00;
    end else begin
      done_r <= cycEnd && !moreCyc;
      if (start) begin
        reqReady_r    <= 1'b0;
        busy_r        <= 1'b1;
        totalStates_r <= total_of(req);
      end else if (cycEnd && !moreCyc) begin
        reqReady_r <= 1'b1;
        busy_r     <= 1'b0;
      end
    end
  end

  assign reqReady    = reqReady_r;
  assign busy        = busy_r;
  assign cycleType   = cycleType_r;
  assign dataWrite   = dataWrite_r;
  assign done        = done_r;
  assign totalStates = totalStates_r;

  // checking helpers
  logic [7:0] elapsed_r;
  logic [7:0] cycLen_r;
  ist_cnt_t   seen_r;
  logic       cycStart_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      elapsed_r  <= 8'h00;
      cycLen_r   <= 8'h00;
      seen_r     <= '0;
      cycStart_r <= 1'b0;
    end else begin
      cycStart_r <= start || (cycEnd && moreCyc);
      if (start) begin
        elapsed_r <= 8'h00;
        seen_r    <= '0;
      end else if (busy_r) begin
        elapsed_r <= elapsed_r + 8'h01;
      end
      if (cycEnd) begin
        seen_r[cycleType_r] <= seen_r[cycleType_r] + 2'h1;
      end
      cycLen_r <= (start || cycEnd) ? 8'h00 : cycLen_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_total_states_sum: assert property (
    done_r |-> elapsed_r == totalStates_r)
    else $error("busy time differs from total states");

  a_fetch_cycle_cost: assert property (
    cycEnd && cycleType_r == CY_FETCH |->
      cycLen_r + 8'h01 == (req_r.fetchLoc == LOC_MEM ? 8'h02 :
        req_r.fetchLoc == LOC_MOD ? 8'h06 :
        8'h06 + {3'h0, req_r.waitStates, 1'b0}))
    else $error("fetch cycle length wrong");

  a_byte_cycle_cost: assert property (
    cycEnd && cycleType_r == CY_BYTE && req_r.dataLoc != LOC_MEM |->
      cycLen_r + 8'h01 == (req_r.dataLoc == LOC_MOD ? 8'h03 :
        8'h03 + {4'h0, req_r.waitStates}))
    else $error("byte cycle length wrong");

  a_word_cycle_cost: assert property (
    cycEnd && cycleType_r == CY_WORD && req_r.dataLoc != LOC_MEM |->
      cycLen_r + 8'h01 == (req_r.dataLoc == LOC_MOD ? 8'h06 :
        8'h06 + {3'h0, req_r.waitStates, 1'b0}))
    else $error("word cycle length wrong");

  a_internal_one_state: assert property (
    cycStart_r && cycleType_r == CY_INTERNAL |-> cycEnd)
    else $error("internal cycle not one state");

  a_ext_wait_stretch: assert property (
    $rose(busy_r) && cycleType_r == CY_FETCH && req_r.fetchLoc == LOC_EXT
      |-> stateLeft_r == 8'h06 + {3'h0, req_r.waitStates, 1'b0})
    else $error("external fetch ignores wait states");

  a_stack_like_fetch: assert property (
    cycStart_r && (cycleType_r == CY_STACK || cycleType_r == CY_BRADDR)
      |-> stateLeft_r == ((cycleType_r == CY_STACK ? req_r.stackLoc :
        req_r.fetchLoc) == LOC_MEM ? 8'h02 :
        (cycleType_r == CY_STACK ? req_r.stackLoc :
        req_r.fetchLoc) == LOC_MOD ? 8'h06 :
        8'h06 + {3'h0, req_r.waitStates, 1'b0}))
    else $error("stack or branch read cost differs from fetch");

  a_alu_one_fetch: assert property (
    done_r && req_r.op == OP_ALU_REG |->
      seen_r[CY_FETCH] == 2'h1 && seen_r[CY_BYTE] == 2'h0)
    else $error("register op cycle mix wrong");

  a_bit_test_mix: assert property (
    done_r && req_r.op == OP_BIT_TEST |->
      seen_r[CY_FETCH] == (req_r.memOperand ? 2'h2 : 2'h1)
      && seen_r[CY_BYTE] == {1'b0, req_r.memOperand})
    else $error("bit test cycle mix wrong");

  a_branch_two_fetch: assert property (
    done_r && req_r.op == OP_BRANCH |->
      seen_r[CY_FETCH] == 2'h2 && seen_r[CY_BYTE] == 2'h0)
    else $error("branch cycle mix wrong");

  a_clear_read_write: assert property (
    cycStart_r && cycleType_r == CY_BYTE && req_r.op == OP_BIT_CLEAR
      |-> dataWrite_r == (seen_r[CY_BYTE] == 2'h1))
    else $error("bit clear read/write order wrong");

  c_ext_bit_clear: cover property (
    done_r && req_r.op == OP_BIT_CLEAR && req_r.memOperand
      && req_r.dataLoc == LOC_EXT);
  c_branch_mod: cover property (
    done_r && req_r.op == OP_BRANCH && req_r.fetchLoc == LOC_MOD);
  c_back_to_back: cover property (done_r ##1 $rose(busy_r));

endmodule
`default_nettype wire

// [hdl/ist_pkg.sv]
`default_nettype none
package ist_pkg;

  // per-cycle state costs
  localparam logic [7:0] COST_ONCHIP_MEM = 8'h02;
  localparam logic [7:0] COST_INTERNAL   = 8'h01;
  localparam logic [7:0] COST_FETCH_MOD  = 8'h06;
  localparam logic [7:0] COST_FETCH_EXT  = 8'h06;
  localparam logic [7:0] COST_BYTE_MOD   = 8'h03;
  localparam logic [7:0] COST_BYTE_EXT   = 8'h03;
  localparam logic [7:0] COST_WORD_MOD   = 8'h06;
  localparam logic [7:0] COST_WORD_EXT   = 8'h06;

  // per-instruction cycle counts
  localparam logic [1:0] CNT_FETCH_REG    = 2'h1;
  localparam logic [1:0] CNT_FETCH_MEM    = 2'h2;
  localparam logic [1:0] CNT_FETCH_BRANCH = 2'h2;
  localparam logic [1:0] CNT_BYTE_TEST    = 2'h1;
  localparam logic [1:0] CNT_BYTE_CLEAR   = 2'h2;

  localparam int unsigned NUM_CYC = 6;

  typedef enum logic [1:0] {
    LOC_MEM = 2'h0,
    LOC_MOD = 2'h1,
    LOC_EXT = 2'h2
  } ist_loc_t;

  typedef enum logic [1:0] {
    OP_ALU_REG   = 2'h0,
    OP_BIT_TEST  = 2'h1,
    OP_BRANCH    = 2'h2,
    OP_BIT_CLEAR = 2'h3
  } ist_op_t;

  typedef enum logic [2:0] {
    CY_FETCH    = 3'h0,
    CY_BRADDR   = 3'h1,
    CY_STACK    = 3'h2,
    CY_BYTE     = 3'h3,
    CY_WORD     = 3'h4,
    CY_INTERNAL = 3'h5
  } ist_cyc_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_RUN  = 2'b10
  } ist_state_t;

  typedef logic [NUM_CYC-1:0][1:0] ist_cnt_t;

  typedef struct packed {
    ist_op_t    op;
    logic       memOperand;
    ist_loc_t   fetchLoc;
    ist_loc_t   stackLoc;
    ist_loc_t   dataLoc;
    logic [3:0] waitStates;
  } ist_req_t;

endpackage
`default_nettype wire

// [verification/ist_access_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ist_access_model (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // observed access cycles
  input  wire logic              busy,
  input  wire ist_pkg::ist_cyc_t cycleType,
  input  wire logic              dataWrite,
  input  wire logic              done,
  // tallies of the finished instruction
  output logic [7:0]             fetchStates,
  output logic [7:0]             readStates,
  output logic [7:0]             writeStates,
  output logic [7:0]             otherStates,
  output logic                   orderErr
);
  import ist_pkg::*;
  logic byteSeen;
  logic writeSeen;
  // each access is held for its full, wait-extended state count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fetchStates <= 8'h00;
      readStates  <= 8'h00;
      writeStates <= 8'h00;
      otherStates <= 8'h00;
      orderErr    <= 1'b0;
      byteSeen    <= 1'b0;
      writeSeen   <= 1'b0;
    end else if (done) begin
      fetchStates <= 8'h00;
      readStates  <= 8'h00;
      writeStates <= 8'h00;
      otherStates <= 8'h00;
      orderErr    <= 1'b0;
      byteSeen    <= 1'b0;
      writeSeen   <= 1'b0;
    end else if (busy) begin
      case (cycleType)
        CY_FETCH: fetchStates <= fetchStates + 8'h01;
        CY_BYTE: begin
          if (dataWrite) begin
            writeStates <= writeStates + 8'h01;
          end else begin
            readStates <= readStates + 8'h01;
          end
        end
        default: otherStates <= otherStates + 8'h01;
      endcase
      orderErr  <= orderErr | (cycleType == CY_FETCH && byteSeen)
                   | (cycleType == CY_BYTE && !dataWrite && writeSeen);
      byteSeen  <= byteSeen | (cycleType == CY_BYTE);
      writeSeen <= writeSeen | (cycleType == CY_BYTE && dataWrite);
    end
  end
endmodule
`default_nettype wire

// [verification/ist_state_timing_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ist_state_timing_tb;
  import ist_pkg::*;
  typedef struct packed {logic [7:0] tot, fs, rs, ws;} ist_exp_t;
  logic       clk_sys  = 1'b0;
  logic       reset_n  = 1'b0;
  logic       reqValid = 1'b0;
  ist_req_t   req      = '0;
  logic       reqReady, busy, dataWrite, done, orderErr;
  ist_cyc_t   cycleType;
  logic [7:0] totalStates, fetchStates, readStates, writeStates, otherStates;
  ist_exp_t   expQ[$];
  ist_exp_t   mon;
  ist_req_t   r;
  int         err_count = 0;
  int         n_tests   = 0;

  always #25 clk_sys = ~clk_sys;

  ist_state_timing i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .busy(busy), .cycleType(cycleType),
    .dataWrite(dataWrite), .done(done), .totalStates(totalStates));
  ist_access_model i_mem (
    .clk_sys(clk_sys), .reset_n(reset_n), .busy(busy),
    .cycleType(cycleType), .dataWrite(dataWrite), .done(done),
    .fetchStates(fetchStates), .readStates(readStates),
    .writeStates(writeStates), .otherStates(otherStates),
    .orderErr(orderErr));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] cost(ist_loc_t l, logic [3:0] m, logic bt);
    if (l == LOC_MEM) return 8'h02;
    if (l == LOC_MOD) return bt ? 8'h03 : 8'h06;
    return bt ? 8'h03 + m : 8'h06 + {m, 1'b0};
  endfunction

  // note expectation, present request, then show junk while busy
  task automatic send(input ist_req_t q);
    ist_exp_t   e;
    logic [1:0] nf;
    logic [1:0] nb;
    int         k;
    for (k = 0; reqReady !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
      if (k > 300) begin
        err_count++;
        $display("unexpected at %0t: request never accepted", $time);
        conclude();
      end
    end
    nf = (q.op == OP_BRANCH || q.memOperand) ? 2'h2 : 2'h1;
    nb = !q.memOperand ? 2'h0 : (q.op == OP_BIT_CLEAR ? 2'h2 : 2'h1);
    e.fs = nf * cost(q.fetchLoc, q.waitStates, 1'b0);
    e.rs = nb == 2'h0 ? 8'h00 : cost(q.dataLoc, q.waitStates, 1'b1);
    e.ws = nb == 2'h2 ? e.rs : 8'h00;
    e.tot = e.fs + e.rs + e.ws;
    expQ.push_back(e);
    reqValid = 1'b1;
    req = q;
    @(posedge clk_sys);
    #1;
    req = rnd();
  endtask

  function automatic ist_req_t rnd();
    ist_req_t   q;
    logic [31:0] v;
    v = $urandom;
    q = v[$bits(ist_req_t)-1:0];
    q.fetchLoc = ist_loc_t'($urandom_range(2));
    q.dataLoc = ist_loc_t'($urandom_range(2));
    q.stackLoc = ist_loc_t'($urandom_range(2));
    if (q.op == OP_ALU_REG || q.op == OP_BRANCH) q.memOperand = 1'b0;
    return q;
  endfunction

  task automatic drain(input string name);
    int k;
    reqValid = 1'b0;
    for (k = 0; k < 400 && expQ.size() != 0; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (expQ.size() != 0) begin
      err_count++;
      $display("unexpected at %0t: instruction never completed", $time);
      conclude();
    end
    $display("test %s done", name);
  endtask

  always @(negedge clk_sys) begin
    if (reset_n && done === 1'b1) begin
      if (expQ.size() == 0) begin
        err_count++;
        $display("unexpected at %0t: completion with nothing sent", $time);
      end else begin
        mon = expQ.pop_front();
        check(totalStates, mon.tot);
        check(fetchStates, mon.fs);
        check(readStates, mon.rs);
        check(writeStates, mon.ws);
        check(otherStates, 8'h00);
        check({7'h00, orderErr}, 8'h00);
      end
    end
  end

  initial begin
    void'($urandom(32'hcdef));
    repeat (4) @(posedge clk_sys);
    #1;
    check({7'h00, reqReady}, 8'h01);
    check({7'h00, busy}, 8'h00);
    check(totalStates, 8'h00);
    reset_n = 1'b1;
    $display("test reset done");
    for (int o = 0; o < 4; o++) begin
      for (int k = 0; k < 18; k++) begin
        r = '0;
        r.op = ist_op_t'(o);
        r.memOperand = k[0] && (o == 1 || o == 3);
        r.fetchLoc = ist_loc_t'(k / 6);
        r.dataLoc = ist_loc_t'((k / 2) % 3);
        r.waitStates = k[3:0];
        send(r);
      end
    end
    drain("matrix");
    repeat (150) send(rnd());
    drain("random");
    r = '0;
    r.op = OP_BIT_CLEAR;
    r.memOperand = 1'b1;
    r.fetchLoc = LOC_EXT;
    r.waitStates = 4'hf;
    send(r);
    repeat (5) @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    reqValid = 1'b0;
    expQ.delete();
    #1;
    check({6'h00, busy, done}, 8'h00);
    check({7'h00, reqReady}, 8'h01);
    @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    r.op = OP_BRANCH;
    r.memOperand = 1'b0;
    send(r);
    drain("midrun reset");
    conclude();
  end
endmodule
`default_nettype wire
